// >>> design/tfpm_pkg.sv
// constants shared by the measurement timer and converter block
package tfpm_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_MODE = 8'hA0;
	localparam logic [7:0] IDX_CNT_LO = 8'hA1;
	localparam logic [7:0] IDX_CNT_HI = 8'hA2;
	localparam logic [7:0] IDX_CONV = 8'hA3;
	localparam logic [7:0] IDX_EDGE = 8'hBF;
	localparam int ADDR_LSB = 2;
	// mode register fields
	localparam int MODE_EN_BIT = 7;
	localparam int MODE_RATE_HI = 6;
	localparam int MODE_RATE_LO = 4;
	localparam int MODE_CKS_BIT = 3;
	localparam int MODE_IEN_BIT = 1;
	localparam int MODE_FLAG_BIT = 0;
	// edge control fields
	localparam int EDGE_WIDTH_BIT = 1;
	localparam int EDGE_DIR_BIT = 0;
	// converter control fields
	localparam int CONV_OUT_BIT = 7;
	localparam int CONV_CH_HI = 2;
	localparam int CONV_CH_LO = 1;
	localparam int CONV_EN_BIT = 0;
	localparam logic [7:0] CONV_WMASK = 8'h87;
	localparam logic [7:0] MODE_WMASK = 8'hFB;
	localparam logic [7:0] EDGE_WMASK = 8'h03;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	// prescaler: code 0 divides by 256, code 7 by 2
	localparam logic [7:0] PRESC_TOP = 8'hFF;
	localparam logic [7:0] PRESC_ZERO = 8'h00;
	localparam logic [7:0] PRESC_ONE = 8'h01;
	localparam int NUM_CH = 3;
	localparam int NUM_SHARED = 4;
	typedef enum logic [1:0] {
		TFPM_WAIT_START = 2'b00,
		TFPM_COUNTING = 2'b01,
		TFPM_DONE = 2'b10
	} tfpm_width_state_t;
endpackage

// >>> design/tfpm_top.sv
// measurement timer/counter with resistance-to-frequency converter front end
//
// Decided for this implementation: the APB slave port.
module tfpm_top #(
	parameter int ADDR_W = 12
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic event_input_pin_i,
	input wire logic converter_sense_input_i,
	output logic [tfpm_pkg::NUM_CH-1:0] channel_drive_o,
	output logic [tfpm_pkg::NUM_CH-1:0] channel_drive_oe_b_o,
	output logic [tfpm_pkg::NUM_CH-1:0] channel_analog_o,
	output logic [tfpm_pkg::NUM_SHARED-1:0] shared_pin_owned_o,
	output logic converter_clock_pin_o,
	output logic converter_clock_pin_oe_b_o,
	output logic converter_clock_pin_owned_o
);

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		reg_hit = (a[ADDR_W-1:tfpm_pkg::ADDR_LSB] == (ADDR_W-tfpm_pkg::ADDR_LSB)'(idx))
			&& (a[tfpm_pkg::ADDR_LSB-1:0] == '0);
	endfunction

	logic [7:0] mode_reg;
	logic [7:0] edge_reg;
	logic [7:0] conv_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [7:0] low_buf_reg;
	logic [7:0] presc_reg;
	logic [31:0] rdata_reg;
	logic [2:0] ev_sync_reg;
	logic [2:0] sense_sync_reg;
	logic charge_reg;
	logic conv_clk_reg;
	tfpm_pkg::tfpm_width_state_t wstate_reg;
	tfpm_pkg::tfpm_width_state_t wstate_next;

	logic setup_ph;
	logic access_ph;
	logic hit_mode, hit_lo, hit_hi, hit_conv, hit_edge, hit_any;
	logic wr_mode, wr_lo, wr_hi, wr_conv, wr_edge, rd_hi;
	logic cnt_en, width_en, edge_dir, cks, conv_en, conv_out_en, conv_en_next;
	logic [2:0] rate;
	logic [1:0] ch_sel;
	logic [7:0] presc_top;
	logic presc_tick;
	logic src_level, src_prev, rise, fall;
	logic start_edge, stop_edge;
	logic ext_mode, tick, overflow, flag_set;

	assign setup_ph = psel_i && !penable_i;
	assign access_ph = psel_i && penable_i;
	assign hit_mode = reg_hit(paddr_i, tfpm_pkg::IDX_MODE);
	assign hit_lo = reg_hit(paddr_i, tfpm_pkg::IDX_CNT_LO);
	assign hit_hi = reg_hit(paddr_i, tfpm_pkg::IDX_CNT_HI);
	assign hit_conv = reg_hit(paddr_i, tfpm_pkg::IDX_CONV);
	assign hit_edge = reg_hit(paddr_i, tfpm_pkg::IDX_EDGE);
	assign hit_any = hit_mode || hit_lo || hit_hi || hit_conv || hit_edge;
	assign wr_mode = access_ph && pwrite_i && hit_mode;
	assign wr_lo = access_ph && pwrite_i && hit_lo;
	assign wr_hi = access_ph && pwrite_i && hit_hi;
	assign wr_conv = access_ph && pwrite_i && hit_conv;
	assign wr_edge = access_ph && pwrite_i && hit_edge;
	// snapshot at the edge that samples the high byte, so both halves match
	assign rd_hi = setup_ph && !pwrite_i && hit_hi;

	// zero wait states; read data is captured in the setup cycle
	assign pready_o = 1'b1;
	assign pslverr_o = access_ph && !hit_any;
	assign prdata_o = rdata_reg;

	assign cnt_en = mode_reg[tfpm_pkg::MODE_EN_BIT];
	assign rate = mode_reg[tfpm_pkg::MODE_RATE_HI:tfpm_pkg::MODE_RATE_LO];
	assign cks = mode_reg[tfpm_pkg::MODE_CKS_BIT];
	assign width_en = edge_reg[tfpm_pkg::EDGE_WIDTH_BIT];
	assign edge_dir = edge_reg[tfpm_pkg::EDGE_DIR_BIT];
	assign conv_en = conv_reg[tfpm_pkg::CONV_EN_BIT];
	assign conv_out_en = conv_reg[tfpm_pkg::CONV_OUT_BIT];
	assign ch_sel = conv_reg[tfpm_pkg::CONV_CH_HI:tfpm_pkg::CONV_CH_LO];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rdata_reg <= '0;
		end else if (setup_ph && !pwrite_i) begin
			rdata_reg <= '0;
			if (hit_mode) begin
				rdata_reg[7:0] <= mode_reg;
			end else if (hit_lo) begin
				rdata_reg[7:0] <= low_buf_reg;
			end else if (hit_hi) begin
				rdata_reg[7:0] <= count_reg[15:8];
			end else if (hit_conv) begin
				rdata_reg[7:0] <= conv_reg;
			end else if (hit_edge) begin
				rdata_reg[7:0] <= edge_reg;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			conv_reg <= tfpm_pkg::RST_BYTE;
		end else if (wr_conv) begin
			conv_reg <= pwdata_i[7:0] & tfpm_pkg::CONV_WMASK;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			edge_reg <= tfpm_pkg::RST_BYTE;
		end else if (wr_edge) begin
			edge_reg <= pwdata_i[7:0] & tfpm_pkg::EDGE_WMASK;
		end
	end

	// request flag: a hardware set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			mode_reg <= tfpm_pkg::RST_BYTE;
		end else begin
			if (wr_mode) begin
				mode_reg <= pwdata_i[7:0] & tfpm_pkg::MODE_WMASK;
			end
			if (flag_set) begin
				mode_reg[tfpm_pkg::MODE_FLAG_BIT] <= 1'b1;
			end
		end
	end

	// pins are asynchronous: two flops, a third only as edge history
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			ev_sync_reg <= '0;
			sense_sync_reg <= '0;
		end else begin
			ev_sync_reg <= {ev_sync_reg[1:0], event_input_pin_i};
			sense_sync_reg <= {sense_sync_reg[1:0], converter_sense_input_i};
		end
	end

	// converter takes over the measured input when enabled
	assign src_level = conv_en ? sense_sync_reg[1] : ev_sync_reg[1];
	assign src_prev = conv_en ? sense_sync_reg[2] : ev_sync_reg[2];
	assign rise = src_level && !src_prev;
	assign fall = !src_level && src_prev;

	// divide by 256 >> rate, so code 0 gives /256 and code 7 gives /2
	// free-running: tick when all masked bits are set, so a rate change cannot stall ticks
	assign presc_top = tfpm_pkg::PRESC_TOP >> rate;
	assign presc_tick = ((presc_reg & presc_top) == presc_top);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			presc_reg <= tfpm_pkg::PRESC_ZERO;
		end else begin
			presc_reg <= presc_reg + tfpm_pkg::PRESC_ONE;
		end
	end

	// width mode: dir 0 measures the high pulse, dir 1 the low pulse
	assign start_edge = edge_dir ? fall : rise;
	assign stop_edge = edge_dir ? rise : fall;

	always_comb begin
		wstate_next = wstate_reg;
		unique case (wstate_reg)
			tfpm_pkg::TFPM_WAIT_START: begin
				if (cnt_en && !mode_reg[tfpm_pkg::MODE_FLAG_BIT] && start_edge) begin
					wstate_next = tfpm_pkg::TFPM_COUNTING;
				end
			end
			tfpm_pkg::TFPM_COUNTING: begin
				if (cnt_en && stop_edge) begin
					wstate_next = tfpm_pkg::TFPM_DONE;
				end
			end
			tfpm_pkg::TFPM_DONE: begin
				if (!mode_reg[tfpm_pkg::MODE_FLAG_BIT]) begin
					wstate_next = tfpm_pkg::TFPM_WAIT_START;
				end
			end
			default: begin
				wstate_next = tfpm_pkg::TFPM_WAIT_START;
			end
		endcase
		if (!width_en) begin
			wstate_next = tfpm_pkg::TFPM_WAIT_START;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			wstate_reg <= tfpm_pkg::TFPM_WAIT_START;
		end else begin
			wstate_reg <= wstate_next;
		end
	end

	// external source only outside width mode
	assign ext_mode = cks && !width_en;
	always_comb begin
		if (!cnt_en) begin
			tick = 1'b0;
		end else if (width_en) begin
			tick = presc_tick && (wstate_reg == tfpm_pkg::TFPM_COUNTING);
		end else if (ext_mode) begin
			tick = edge_dir ? rise : fall;
		end else begin
			tick = presc_tick;
		end
	end

	// overflow flags only outside width mode; width mode flags on the stop edge
	assign overflow = tick && !width_en && (count_reg == tfpm_pkg::COUNT_MAX);
	assign flag_set = overflow || (width_en && cnt_en
		&& wstate_reg == tfpm_pkg::TFPM_COUNTING && stop_edge);

	always_comb begin
		count_next = count_reg;
		if (wr_hi) begin
			count_next = {pwdata_i[7:0], low_buf_reg};
		end else if (tick) begin
			count_next = count_reg + tfpm_pkg::COUNT_ONE;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			count_reg <= tfpm_pkg::RST_COUNT;
		end else begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			low_buf_reg <= tfpm_pkg::RST_BYTE;
		end else if (wr_lo) begin
			low_buf_reg <= pwdata_i[7:0];
		end else if (rd_hi) begin
			low_buf_reg <= count_reg[7:0];
		end
	end

	// relaxation control: charge while sense is low, discharge once high
	// charge follows the enable being written, so drive never outlives the converter
	assign conv_en_next = wr_conv ? pwdata_i[tfpm_pkg::CONV_EN_BIT] : conv_en;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			charge_reg <= 1'b0;
			conv_clk_reg <= 1'b0;
		end else begin
			charge_reg <= conv_en_next && !sense_sync_reg[1];
			conv_clk_reg <= conv_en && sense_sync_reg[1];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < tfpm_pkg::NUM_CH; gi++) begin : g_ch
			assign channel_drive_o[gi] = charge_reg;
			// reserved code 11 drives no channel and leaves all analog
			assign channel_drive_oe_b_o[gi] = !(conv_en && ch_sel == 2'(gi));
			assign channel_analog_o[gi] = conv_en && ch_sel != 2'(gi);
		end
	endgenerate

	assign shared_pin_owned_o = {tfpm_pkg::NUM_SHARED{conv_en}};
	assign converter_clock_pin_o = conv_clk_reg;
	assign converter_clock_pin_oe_b_o = !conv_out_en;
	assign converter_clock_pin_owned_o = conv_out_en;

endmodule // tfpm_top

// >>> test/tfpm_top_props.sv
// port-level checker for the measurement timer block
module tfpm_chk #(
	parameter int ADDR_W = 12
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire logic converter_sense_input_i,
	input wire logic [2:0] channel_drive_o,
	input wire logic [2:0] channel_drive_oe_b_o,
	input wire logic [2:0] channel_analog_o,
	input wire logic [3:0] shared_pin_owned_o,
	input wire logic converter_clock_pin_o,
	input wire logic converter_clock_pin_oe_b_o,
	input wire logic converter_clock_pin_owned_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic sen_q;
	logic [2:0] st_q;
	logic rd_acc;
	assign rd_acc = psel_i && penable_i && !pwrite_i;
	// sense must sit still long enough to pass the synchroniser
	always_ff @(posedge sys_clk_i) begin
		sen_q <= converter_sense_input_i;
		if (!rst_b_i || !shared_pin_owned_o[0] || converter_sense_input_i != sen_q) begin
			st_q <= 3'h0;
		end else if (st_q != 3'h7) begin
			st_q <= st_q + 3'h1;
		end
	end
	a_off_released: assert property (!shared_pin_owned_o[0] |-> channel_drive_oe_b_o == 3'h7
		&& channel_analog_o == 3'h0 && channel_drive_o == 3'h0) else $error("pins held while off");
	a_drive_owns: assert property (channel_drive_oe_b_o != 3'h7 |-> shared_pin_owned_o == 4'hF
		&& $countones(~channel_drive_oe_b_o) == 1) else $error("drive without ownership");
	a_analog_rest: assert property (shared_pin_owned_o[0] |->
		(channel_analog_o ^ ~channel_drive_oe_b_o) == 3'h7) else $error("channel state wrong");
	a_clk_pin_oe: assert property (converter_clock_pin_oe_b_o != converter_clock_pin_owned_o)
		else $error("clock pin enable wrong");
	a_clk_follow: assert property (st_q >= 3'h4 |->
		converter_clock_pin_o == sen_q) else $error("clock pin not sense");
	a_hi_zero: assert property (rd_acc |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_conv_gap: assert property (rd_acc && paddr_i == 12'h28C |-> prdata_o[6:3] == 4'h0)
		else $error("converter gap bits set");
	a_conv_map: assert property (psel_i && penable_i && paddr_i == 12'h28C |-> !pslverr_o)
		else $error("converter access refused");
	c_ch2: cover property (!channel_drive_oe_b_o[2]);
	c_err: cover property (pslverr_o);
	c_clk: cover property (st_q == 3'h7 && converter_clock_pin_o);
endmodule // tfpm_chk

bind tfpm_top tfpm_chk #(.ADDR_W(ADDR_W)) tfpm_chk_i (.*);

// >>> test/tfpm_pin_src.sv
// pulse source for the event pin and the converter sense node
module tfpm_pin_src (
	input wire logic clk_i,
	output logic ev_o,
	output logic sense_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// no pull on the shared pins: only this model sets their level
	initial begin
		ev_o = 1'h0;
		sense_o = 1'h0;
	end
	// sense line stands in for the rc node swinging between thresholds
	task automatic lvl(input logic s, input logic v, input int w);
		@(posedge clk_i);
		if (s) sense_o <= v;
		else ev_o <= v;
		repeat (w) @(posedge clk_i);
	endtask
endmodule // tfpm_pin_src

// >>> test/timer_freq_pulse_measure_rconv_tb.sv
// self-checking bench for the measurement timer block
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module timer_freq_pulse_measure_rconv_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, psel, pen, pwr, rdy, err, ev, sns, cko, ckoeb, ckown, serr;
	logic [11:0] addr;
	logic [31:0] wdat, rdat, r;
	logic [2:0] drv, oeb, ana;
	logic [3:0] own;
	logic [15:0] v;
	int miscompares = 0;
	int check_count = 0;
	tfpm_top #(.ADDR_W(12)) tfpm_top_i (.sys_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .prdata_o(rdat),
		.pready_o(rdy), .pslverr_o(err), .event_input_pin_i(ev), .converter_sense_input_i(sns),
		.channel_drive_o(drv), .channel_drive_oe_b_o(oeb), .channel_analog_o(ana),
		.shared_pin_owned_o(own), .converter_clock_pin_o(cko),
		.converter_clock_pin_oe_b_o(ckoeb), .converter_clock_pin_owned_o(ckown));
	tfpm_pin_src tfpm_pin_src_i (.clk_i(clk), .ev_o(ev), .sense_o(sns));
	task automatic final_report();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		addr <= 12'({idx, 2'h0});
		wdat <= {24'h0, d};
		@(posedge clk);
		pen <= 1'h1;
		// slave latency is not assumed; pready is judged at each rising edge
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'h1 && n < 20);
		if (rdy !== 1'h1) begin
			miscompares++;
			final_report();
		end
		r = rdat;
		serr = err;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task automatic rdc();
		apb(1'h0, tfpm_pkg::IDX_CNT_HI, 8'h0);
		v[15:8] = r[7:0];
		apb(1'h0, tfpm_pkg::IDX_CNT_LO, 8'h0);
		v[7:0] = r[7:0];
	endtask
	task automatic load0();
		apb(1'h1, tfpm_pkg::IDX_CNT_LO, 8'h0);
		apb(1'h1, tfpm_pkg::IDX_CNT_HI, 8'h0);
	endtask
	task automatic t_regs();
		logic [7:0] ix[5] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hBF};
		foreach (ix[i]) begin
			apb(1'h0, ix[i], 8'h0);
			`CHK("reset value", 32'h0, r)
		end
		apb(1'h1, tfpm_pkg::IDX_CONV, 8'hFF);
		apb(1'h0, tfpm_pkg::IDX_CONV, 8'h0);
		`CHK("conv bits", 32'h87, r)
		`CHK("conv error", 1'h0, serr)
		apb(1'h1, 8'hA4, 8'h55);
		apb(1'h0, 8'hA4, 8'h0);
		`CHK("slave error", 1'h1, serr)
		`CHK("unmapped", 32'h0, r)
		apb(1'h1, tfpm_pkg::IDX_MODE, 8'h76);
		apb(1'h0, tfpm_pkg::IDX_MODE, 8'h0);
		`CHK("mode rate", 32'h72, r)
		apb(1'h1, tfpm_pkg::IDX_MODE, 8'h0);
	endtask
	task automatic t_conv();
		for (int c = 0; c < 4; c++) begin
			apb(1'h1, tfpm_pkg::IDX_CONV, 8'(c * 2 + 1 + (c % 2) * 128));
			@(negedge clk);
			`CHK("drive enable", 3'h7 ^ (3'h1 << c), oeb)
			`CHK("analog", 3'h7 ^ (3'h1 << c), ana)
			`CHK("owned", 4'hF, own)
			`CHK("clock pin oe", 1'(~c), ckoeb)
			`CHK("clock pin owned", 1'(c), ckown)
			`CHK("charge drive", 3'h7, drv)
		end
		apb(1'h1, tfpm_pkg::IDX_CONV, 8'h0);
		@(negedge clk);
		`CHK("released", 4'h0, own)
		`CHK("drive off", 3'h0, drv)
	endtask
	task automatic t_load();
		apb(1'h1, tfpm_pkg::IDX_CNT_LO, 8'h34);
		apb(1'h1, tfpm_pkg::IDX_CNT_HI, 8'h12);
		// stale low buffer must be overwritten by the high-byte read
		apb(1'h1, tfpm_pkg::IDX_CNT_LO, 8'h99);
		rdc();
		`CHK("count load", 16'h1234, v)
	endtask
	// enabled for exactly n prescaler periods: access edges bracket n*period edges
	task automatic t_timer(input logic [2:0] code, input int n);
		load0();
		apb(1'h1, tfpm_pkg::IDX_MODE, {1'h1, code, 4'h0});
		repeat (n * (256 >> code) - 3) @(posedge clk);
		apb(1'h1, tfpm_pkg::IDX_MODE, {1'h0, code, 4'h0});
		rdc();
		`CHK("timer ticks", 16'(n), v)
	endtask
	task automatic t_event(input logic dir, input logic conv);
		load0();
		apb(1'h1, tfpm_pkg::IDX_CONV, {7'h0, conv});
		apb(1'h1, tfpm_pkg::IDX_EDGE, {7'h0, dir});
		apb(1'h1, tfpm_pkg::IDX_MODE, 8'h88);
		repeat (4) begin
			tfpm_pin_src_i.lvl(conv, 1'h1, 4);
			tfpm_pin_src_i.lvl(conv, 1'h0, 4);
		end
		tfpm_pin_src_i.lvl(conv, 1'h1, 8);
		if (conv) tfpm_pin_src_i.lvl(1'h0, 1'h1, 8);
		// end of the gate period the bench plays as the other timer
		apb(1'h1, tfpm_pkg::IDX_MODE, 8'h08);
		tfpm_pin_src_i.lvl(conv, 1'h0, 4);
		tfpm_pin_src_i.lvl(1'h0, 1'h0, 4);
		rdc();
		`CHK("event count", dir ? 16'h5 : 16'h4, v)
		apb(1'h1, tfpm_pkg::IDX_CONV, 8'h0);
	endtask
	task automatic t_width(input logic dir);
		tfpm_pin_src_i.lvl(1'h0, dir, 4);
		load0();
		apb(1'h1, tfpm_pkg::IDX_EDGE, {6'h0, 1'h1, dir});
		apb(1'h1, tfpm_pkg::IDX_MODE, 8'hF0);
		tfpm_pin_src_i.lvl(1'h0, ~dir, 40);
		tfpm_pin_src_i.lvl(1'h0, dir, 10);
		apb(1'h0, tfpm_pkg::IDX_MODE, 8'h0);
		`CHK("flag set", 32'hF1, r)
		rdc();
		`CHK("width", 1'h1, v >= 16'd19 && v <= 16'd21)
		apb(1'h1, tfpm_pkg::IDX_MODE, 8'hF0);
		tfpm_pin_src_i.lvl(1'h0, ~dir, 20);
		// read while the pulse is still being timed
		rdc();
		`CHK("live count", 1'h1, v >= 16'd28 && v <= 16'd31)
		tfpm_pin_src_i.lvl(1'h0, dir, 10);
		rdc();
		`CHK("rearm", 1'h1, v >= 16'd33 && v <= 16'd35)
		apb(1'h1, tfpm_pkg::IDX_MODE, 8'h0);
		apb(1'h1, tfpm_pkg::IDX_EDGE, 8'h0);
		tfpm_pin_src_i.lvl(1'h0, 1'h0, 4);
	endtask
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		final_report();
	end
	initial begin
		{rst_b, psel, pen, pwr, addr, wdat} = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		t_regs();
		t_conv();
		t_load();
		t_timer(3'h7, 20);
		t_timer(3'h4, 10);
		t_timer(3'h0, 2);
		t_event(1'h0, 1'h0);
		t_event(1'h1, 1'h0);
		t_event(1'h1, 1'h1);
		t_width(1'h0);
		t_width(1'h1);
		final_report();
	end
endmodule // timer_freq_pulse_measure_rconv_tb
